//--- logic/nxse_exec.sv
// Purpose: Executes store-back subtract and xor instructions in one cycle.
// Assumes: Operand reads from data memory and working registers are
//          combinational and settle within the issue cycle.
// Notes: Owns the result nibble and both flags; memory and register
//        writes leave as one-cycle strobes for the core to apply.
`timescale 1ns/100ps
`default_nettype none
module nxse_exec
    import nxse_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic insn_valid,
    input wire logic [nxse_pkg::INSN_W-1:0] insn,
    // Operand reads
    output logic [nxse_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [nxse_pkg::DATA_W-1:0] mem_rdata,
    output logic [nxse_pkg::WREG_W-1:0] wreg_sel,
    input wire logic [nxse_pkg::DATA_W-1:0] wreg_rdata,
    // Write-back strobes
    output logic mem_we,
    output logic [nxse_pkg::ADDR_W-1:0] mem_waddr,
    output logic [nxse_pkg::DATA_W-1:0] mem_wdata,
    output logic wreg_we,
    output logic [nxse_pkg::WREG_W-1:0] wreg_waddr,
    output logic [nxse_pkg::DATA_W-1:0] wreg_wdata,
    // Core state
    output logic [nxse_pkg::DATA_W-1:0] result_nibble_reg,
    output logic carry_flag,
    output logic zero_flag,
    output logic insn_hit
);
    import nxse_pkg::*;

    nxse_op_t op;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic [DATA_W-1:0] alu_res;
    logic alu_carry;
    logic alu_zero;
    logic is_sub;
    logic uses_mem;
    logic wr_mem;
    logic wr_reg;
    logic [DATA_W-1:0] result_q, result_d;
    logic carry_q, carry_d;
    logic zero_q, zero_d;
    logic mem_we_q, wreg_we_q;
    logic [ADDR_W-1:0] mem_waddr_q;
    logic [WREG_W-1:0] wreg_waddr_q;
    logic [DATA_W-1:0] wdata_q;

    // Decode by opcode prefix.
    wire hit_sub_wb = insn[INSN_W-1 -: SUB_WB_LEN] == SUB_WB_OP;
    wire hit_xor_mem = insn[INSN_W-1 -: XOR_MEM_LEN] == XOR_MEM_OP;
    wire hit_xor_mem_wb = insn[INSN_W-1 -: XOR_MEM_WB_LEN] == XOR_MEM_WB_OP;
    wire hit_xor_imm = insn[INSN_W-1 -: XOR_IMM_LEN] == XOR_IMM_OP;
    wire hit_xor_imm_wb = insn[INSN_W-1 -: XOR_IMM_WB_LEN] == XOR_IMM_WB_OP;

    // The memory xor without store-back shares its top byte with the
    // register xor without store-back, so the longer prefixes are tested before the register xor prefixes.
    // A register xor without store-back whose top immediate bit is clear therefore runs as
    // the memory form; software must not rely on that immediate range.
    assign op = !insn_valid ? NXSE_OP_NONE :
                hit_sub_wb ? NXSE_OP_SUB_WB :
                hit_xor_mem ? NXSE_OP_XOR_MEM :
                hit_xor_mem_wb ? NXSE_OP_XOR_MEM_WB :
                hit_xor_imm ? NXSE_OP_XOR_IMM :
                hit_xor_imm_wb ? NXSE_OP_XOR_IMM_WB : NXSE_OP_NONE;

    assign imm = insn[IMM_LSB +: DATA_W];
    assign mem_addr = insn[ADDR_LSB +: ADDR_W];
    assign wreg_sel = insn[WR_LSB +: WREG_W];

    assign is_sub = (op == NXSE_OP_SUB_WB);
    assign uses_mem = (op == NXSE_OP_XOR_MEM) ||
                      (op == NXSE_OP_XOR_MEM_WB);
    assign wr_mem = (op == NXSE_OP_XOR_MEM_WB);
    assign wr_reg = (op == NXSE_OP_SUB_WB) ||
                    (op == NXSE_OP_XOR_IMM_WB);
    assign insn_hit = (op != NXSE_OP_NONE);

    // Memory forms pair the nibble with the result register; register forms
    // pair the working register with the immediate.
    assign opa = uses_mem ? mem_rdata : wreg_rdata;
    assign opb = uses_mem ? result_q : imm;

    nxse_alu u_alu (
        .opa(opa),
        .opb(opb),
        .sub_sel(is_sub),
        .res(alu_res),
        .carry(alu_carry),
        .zero(alu_zero)
    );

    // Every decoded form lands its result in the result register.
    assign result_d = insn_hit ? alu_res : result_q;
    assign zero_d = insn_hit ? alu_zero : zero_q;
    // Only the subtract touches carry; xor forms leave it alone.
    assign carry_d = is_sub ? alu_carry : carry_q;

    // All forms complete in a single cycle, so no state machine is needed.
    // Each register has its own short process so that the reset value and
    // the next value of every piece of core state can be read at a glance.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_q <= RESULT_RST;
        end
        else
        begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            carry_q <= CARRY_RST;
        end
        else
        begin
            carry_q <= carry_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_q <= ZERO_RST;
        end
        else
        begin
            zero_q <= zero_d;
        end
    end

    // The write strobes rise with the result, one cycle after issue. The core has to
    // forward the result itself if the next word reads the same location,
    // because the store has not landed yet at that point.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_we_q <= 1'b0;
        end
        else
        begin
            mem_we_q <= wr_mem;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wreg_we_q <= 1'b0;
        end
        else
        begin
            wreg_we_q <= wr_reg;
        end
    end

    // Addresses and data are captured every cycle; they only matter while
    // the matching strobe is high, so no enable is spent on them.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_waddr_q <= '0;
        end
        else
        begin
            mem_waddr_q <= mem_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wreg_waddr_q <= '0;
        end
        else
        begin
            wreg_waddr_q <= wreg_sel;
        end
    end

    // One data register feeds both write ports, since no form stores to
    // memory and to a working register in the same cycle.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdata_q <= '0;
        end
        else
        begin
            wdata_q <= alu_res;
        end
    end

    assign result_nibble_reg = result_q;
    assign carry_flag = carry_q;
    assign zero_flag = zero_q;
    assign mem_we = mem_we_q;
    assign mem_waddr = mem_waddr_q;
    assign mem_wdata = wdata_q;
    assign wreg_we = wreg_we_q;
    assign wreg_waddr = wreg_waddr_q;
    assign wreg_wdata = wdata_q;
endmodule
`default_nettype wire

//--- pkg/nxse_pkg.sv
// Purpose: Constants for the xor and subtract execution unit.
// Assumes: 16-bit instruction words, 4-bit data, 7-bit data addresses.
// Notes: Opcode prefixes are matched against the top bits of the word.
package nxse_pkg;
    localparam int DATA_W = 4;
    localparam int ADDR_W = 7;
    localparam int WREG_W = 4;
    localparam int INSN_W = 16;
    // Opcode prefixes and their widths, taken from the top of the word.
    localparam int SUB_WB_LEN = 8;
    localparam logic [7:0] SUB_WB_OP = 8'h1F;
    localparam int XOR_MEM_LEN = 9;
    localparam logic [8:0] XOR_MEM_OP = 9'h070;
    localparam int XOR_MEM_WB_LEN = 9;
    localparam logic [8:0] XOR_MEM_WB_OP = 9'h072;
    localparam int XOR_IMM_LEN = 8;
    localparam logic [7:0] XOR_IMM_OP = 8'h38;
    localparam int XOR_IMM_WB_LEN = 8;
    localparam logic [7:0] XOR_IMM_WB_OP = 8'h3A;
    // Field positions.
    localparam int IMM_LSB = 4;
    localparam int WR_LSB = 0;
    localparam int ADDR_LSB = 0;
    // Reset values.
    localparam logic [3:0] RESULT_RST = 4'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic ZERO_RST = 1'b0;
    // Operation select codes.
    typedef enum logic [2:0] {
        NXSE_OP_NONE = 3'b000,
        NXSE_OP_SUB_WB = 3'b001,
        NXSE_OP_XOR_MEM = 3'b011,
        NXSE_OP_XOR_IMM = 3'b010,
        NXSE_OP_XOR_MEM_WB = 3'b110,
        NXSE_OP_XOR_IMM_WB = 3'b111
    } nxse_op_t;
endpackage

//--- logic/nxse_alu.sv
// Purpose: Combinational nibble xor and subtract with flag results.
// Assumes: Carry reports a borrow when the subtrahend exceeds the minuend.
// Notes: Pure logic; the caller decides which flags to keep.
`timescale 1ns/100ps
`default_nettype none
module nxse_alu
    import nxse_pkg::*;
(
    // Operands
    input wire logic [nxse_pkg::DATA_W-1:0] opa,
    input wire logic [nxse_pkg::DATA_W-1:0] opb,
    input wire logic sub_sel,
    // Results
    output logic [nxse_pkg::DATA_W-1:0] res,
    output logic carry,
    output logic zero
);
    logic [DATA_W:0] diff;
    assign diff = {1'b0, opa} - {1'b0, opb};
    assign res = sub_sel ? diff[DATA_W-1:0] : (opa ^ opb);
    // Borrow convention: carry set means a borrow occurred.
    assign carry = sub_sel & diff[DATA_W];
    assign zero = (res == '0);
endmodule
`default_nettype wire

//--- tb/nxse_exec_checker.sv
// Purpose: Port checks for the xor and subtract unit.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Prefixes are spelled out so a decode slip shows.
`timescale 1ns/100ps
`default_nettype none
module nxse_exec_checker (
    // Clock and issue
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] insn,
    input wire logic insn_hit,
    // Operands, strobes and state
    input wire logic [3:0] mem_rdata,
    input wire logic [3:0] wreg_rdata,
    input wire logic mem_we,
    input wire logic [6:0] mem_waddr,
    input wire logic [3:0] mem_wdata,
    input wire logic wreg_we,
    input wire logic [3:0] wreg_waddr,
    input wire logic [3:0] wreg_wdata,
    input wire logic [3:0] result_nibble_reg,
    input wire logic carry_flag,
    input wire logic zero_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic s_go = insn_hit && insn[15:8] == 8'h1F;
    wire logic xm_go = insn_hit && insn[15:7] == 9'h070;
    wire logic xb_go = insn_hit && insn[15:7] == 9'h072;
    wire logic xw_go = insn_hit && insn[15:8] == 8'h38 && insn[7];
    wire logic wb_go = insn_hit && insn[15:8] == 8'h3A;
    sub_write_a: assert property (
        s_go |=> wreg_we && wreg_waddr == $past(insn[3:0])
        && wreg_wdata == result_nibble_reg) else $error("sub store");
    sub_value_a: assert property (
        s_go |=> result_nibble_reg == $past(wreg_rdata - insn[7:4])
        && carry_flag == $past(wreg_rdata < insn[7:4])) else $error("sub");
    xor_mem_a: assert property (
        xm_go |=> result_nibble_reg == $past(mem_rdata ^ result_nibble_reg)
        && !mem_we && !wreg_we && $stable(carry_flag)) else $error("xm");
    xor_imm_a: assert property (
        xw_go |=> result_nibble_reg == $past(wreg_rdata ^ insn[7:4])
        && !wreg_we && !mem_we) else $error("xor imm");
    mem_back_a: assert property (
        xb_go |=> mem_we && mem_waddr == $past(insn[6:0])
        && mem_wdata == result_nibble_reg) else $error("mem store");
    reg_back_a: assert property (
        wb_go |=> wreg_we && wreg_wdata == result_nibble_reg
        && wreg_waddr == $past(insn[3:0])) else $error("reg store");
    zero_follow_a: assert property (
        insn_hit |=> zero_flag == (result_nibble_reg == 4'h0))
        else $error("zero flag");
    miss_hold_a: assert property (
        !insn_hit |=> $stable(result_nibble_reg) && !mem_we && !wreg_we)
        else $error("miss changed state");
    sub_c: cover property (s_go ##1 carry_flag);
    mem_c: cover property (xb_go);
    imm_c: cover property (wb_go ##1 zero_flag);
endmodule
bind nxse_exec nxse_exec_checker u_chk (.*);
`default_nettype wire

//--- tb/nxse_exec_test.sv
// Purpose: Directed test of the xor and subtract unit.
// Assumes: Operands are driven in place of memory and registers.
// Notes: Ops run back to back; inputs move 1 ns after each edge.
`timescale 1ns/100ps
`default_nettype none
module nxse_exec_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic insn_valid = 1'b0;
    logic [15:0] insn = 16'h0000;
    logic [3:0] mem_rdata = 4'h0;
    logic [3:0] wreg_rdata = 4'h0;
    logic [6:0] mem_addr, mem_waddr;
    logic [3:0] wreg_sel, mem_wdata, wreg_waddr, wreg_wdata, res;
    logic mem_we, wreg_we, carry_flag, zero_flag, insn_hit;
    int bad_count = 0;
    int n_compared = 0;
    always #5 core_clk = ~core_clk;
    nxse_exec u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .insn_valid(insn_valid), .insn(insn), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .wreg_sel(wreg_sel), .wreg_rdata(wreg_rdata),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .wreg_we(wreg_we), .wreg_waddr(wreg_waddr), .wreg_wdata(wreg_wdata),
        .result_nibble_reg(res), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .insn_hit(insn_hit));
    task automatic chk(input string nm, input logic [6:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Issues one word and checks the state that the edge leaves behind.
    task automatic op(input logic [15:0] i, input logic [3:0] m, w, r,
        input logic z, c);
        logic h;
        h = (i[15:8] == 8'h1F) || (i[15:8] == 8'h38)
            || (i[15:8] == 8'h3A) || (i[15:7] == 9'h072);
        insn_valid = 1'b1;
        insn = i;
        mem_rdata = m;
        wreg_rdata = w;
        #1;
        chk("insn_hit", {6'h00, insn_hit}, {6'h00, h});
        chk("mem_addr", mem_addr, i[6:0]);
        chk("wreg_sel", {3'h0, wreg_sel}, {3'h0, i[3:0]});
        @(posedge core_clk);
        #1;
        chk("result", {3'h0, res}, {3'h0, r});
        chk("zero", {6'h00, zero_flag}, {6'h00, z});
        chk("carry", {6'h00, carry_flag}, {6'h00, c});
        chk("mem_we", {6'h00, mem_we}, {6'h00, i[15:7] == 9'h072});
        chk("wreg_we", {6'h00, wreg_we}, {6'h00, i[15:8] == 8'h1F
            || i[15:8] == 8'h3A});
    endtask
    // Presents a decodable word without the issue qualifier.
    task automatic quiet(input logic [15:0] i);
        logic [3:0] r0;
        r0 = res;
        insn_valid = 1'b0;
        insn = i;
        #1;
        chk("idle hit", {6'h00, insn_hit}, 7'h00);
        @(posedge core_clk);
        #1;
        chk("idle result", {3'h0, res}, {3'h0, r0});
        chk("idle wreg_we", {6'h00, wreg_we}, 7'h00);
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        chk("reset result", {3'h0, res}, 7'h00);
        chk("reset carry", {6'h00, carry_flag}, 7'h00);
        chk("reset zero", {6'h00, zero_flag}, 7'h00);
        op(16'h1F53, 4'h0, 4'h7, 4'h2, 1'b0, 1'b0);
        chk("wreg_waddr", {3'h0, wreg_waddr}, 7'h03);
        chk("wreg_wdata", {3'h0, wreg_wdata}, 7'h02);
        op(16'h1F44, 4'h0, 4'h4, 4'h0, 1'b1, 1'b0);
        op(16'h1F72, 4'h0, 4'h3, 4'hC, 1'b0, 1'b1);
        op(16'h3805, 4'h6, 4'h0, 4'hA, 1'b0, 1'b1);
        op(16'h3805, 4'hA, 4'h0, 4'h0, 1'b1, 1'b1);
        op(16'h38A2, 4'h0, 4'h3, 4'h9, 1'b0, 1'b1);
        op(16'h3955, 4'h3, 4'h0, 4'hA, 1'b0, 1'b1);
        chk("mem_waddr", mem_waddr, 7'h55);
        chk("mem_wdata", {3'h0, mem_wdata}, 7'h0A);
        op(16'h3AF6, 4'h0, 4'hF, 4'h0, 1'b1, 1'b1);
        chk("wreg_waddr", {3'h0, wreg_waddr}, 7'h06);
        op(16'hFFFF, 4'h5, 4'h5, 4'h0, 1'b1, 1'b1);
        quiet(16'h3AF6);
        finish_test();
    end
endmodule
`default_nettype wire
